// file: common/mqf_pkg.sv
// Package for the multi-queue flag and null-queue block: constants and port carriers
package mqf_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int QUEUES = 4;
	localparam int QSEL_W = 2;
	localparam int DEVID_W = 3;
	localparam int BYTE_W = 9;
	localparam int WORD_W = 18;
	localparam int WADDR_W = 5;
	localparam int RADDR_W = 6;
	localparam int RADDR_NULL_BIT = 2;
	localparam int RADDR_ID_LSB = 3;
	localparam int WADDR_ID_LSB = 2;

	// ------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LEVEL0 = 8'h10;
	localparam logic [7:0] REG_LEVEL_STEP = 8'h04;
	localparam int CTRL_WR_ENABLE_BIT = 0;
	localparam int CTRL_RD_ENABLE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	localparam int STAT_FULL_LSB = 0;
	localparam int STAT_EMPTY_LSB = 4;
	localparam int STAT_WNARROW_BIT = 8;
	localparam int STAT_RNARROW_BIT = 9;
	localparam int STAT_ID_LSB = 12;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic FLAG_RESET_N = 1'b1;
	localparam logic [QSEL_W-1:0] QSEL_RESET = 2'h0;

	// ------------------------------------------------------------
	// Port carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic selStrobe;
		logic [WADDR_W-1:0] selBus;
		logic enable;
		logic [WORD_W-1:0] data;
	} mqf_wr_port_s;

	typedef struct packed {
		logic selStrobe;
		logic [RADDR_W-1:0] selBus;
		logic enable;
	} mqf_rd_port_s;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} mqf_wb_req_s;

endpackage

// file: rtl/mqf_queue_core.sv
// Four-queue store with null-queue read select, bus matching and shared full flag
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
// ------------------------------------------------------------
// How it works
// R1: read address bit two selects null queue
// R2: null queue acts empty, last word kept
// R3: pipeline keeps draining after null switch
// R4: last queue word falls through unaided
// R5: null select works in every read mode
// R6: write port has no null queue
// R7: controller parks reads on null queue
// R8: width selects latched during master reset
// R9: bytes ordered little endian in words
// R10: full counted in write-width units
// R11: valid counted in read-width units
// R12: one width pair for all queues
// R13: full tracked per queue, active shown
// R14: full shows new queue next edge
// R15: new queue written from second edge
// R16: full flag changes only on clock edges
// R17: inactive queue full clears on reads
// R18: controller watches one shared full line
// R19: one device write target at once
// R20: drive full while address ID matches
// R21: float full when ID mismatches
// R22: five-bit write address, ID upper bits
// R23: six-bit read address, ID upper bits
// R24: output load also updates valid flag
// R25: full output active low
// R26: writes into full queue dropped
// ------------------------------------------------------------
module mqf_queue_core #(
	parameter int DEPTH = 1024
)(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Static straps
	input wire logic [mqf_pkg::DEVID_W-1:0] deviceIdentPins,
	input wire logic inputWidthSelect,
	input wire logic outputWidthSelect,
	// Write port
	input wire mqf_pkg::mqf_wr_port_s wrPort,
	output logic activeQueueFull_n,
	output logic activeQueueFullOe,
	// Read port
	input wire mqf_pkg::mqf_rd_port_s rdPort,
	output logic [mqf_pkg::WORD_W-1:0] readData,
	output logic outputWordValid_n,
	output logic outputWordValidOe,
	// Wishbone slave
	input wire mqf_pkg::mqf_wb_req_s wbReq,
	output logic [31:0] wbDatOut,
	output logic wbAck
);
	import mqf_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

	// Number of bytes a port moves per transfer
	function automatic logic [CNT_W-1:0] unitBytes(input logic narrow);
		unitBytes = narrow ? CNT_W'(1) : CNT_W'(2);
	endfunction

	// ------------------------------------------------------------
	// Strap synchronisers and master-reset latch
	// ------------------------------------------------------------
	logic [DEVID_W+1:0] strapMeta_r;
	logic [DEVID_W+1:0] strapSync_r;
	logic wrNarrow_r;
	logic rdNarrow_r;
	logic [DEVID_W-1:0] devId;

	// Two flops before anything looks at the straps
	always_ff @(posedge ref_clk)
	begin
		strapMeta_r <= {inputWidthSelect, outputWidthSelect, deviceIdentPins};
		strapSync_r <= strapMeta_r;
	end

	// Widths only follow the straps while reset is held; hold reset >= 3 edges
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wrNarrow_r <= strapSync_r[DEVID_W+1]; // R8 R12
			rdNarrow_r <= strapSync_r[DEVID_W]; // R8 R12
		end
	end

	assign devId = strapSync_r[DEVID_W-1:0];

	logic [CNT_W-1:0] wrBytes;
	logic [CNT_W-1:0] rdBytes;
	assign wrBytes = unitBytes(wrNarrow_r);
	assign rdBytes = unitBytes(rdNarrow_r);

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	logic [1:0] ctrl_r;

	// ------------------------------------------------------------
	// Per-queue storage and occupancy
	// ------------------------------------------------------------
	logic [BYTE_W-1:0] mem [QUEUES*DEPTH];
	logic [PTR_W-1:0] wrPtr_r [QUEUES];
	logic [PTR_W-1:0] rdPtr_r [QUEUES];
	logic [CNT_W-1:0] cnt_r [QUEUES];
	logic [CNT_W-1:0] cntNxt [QUEUES];
	logic [QUEUES-1:0] qFull;
	logic [QUEUES-1:0] qEmpty;
	logic [QUEUES-1:0] qFullNxt;
	logic [QUEUES-1:0] doWrite;
	logic [QUEUES-1:0] doPop;

	// ------------------------------------------------------------
	// Write-port selection
	// ------------------------------------------------------------
	logic [QSEL_W-1:0] wrSelQ_r;
	logic wrSelOwn_r;
	logic [QSEL_W-1:0] wrActQ_r;
	logic wrActOwn_r;
	logic wrSelHit;

	// Upper three address bits pick the device, lower two the queue
	assign wrSelHit = wrPort.selBus[WADDR_W-1:WADDR_ID_LSB] == devId; // R22

	// Selection latched on the strobe edge; there is no null code here
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wrSelQ_r <= QSEL_RESET;
			wrSelOwn_r <= 1'b0;
		end
		else if (wrPort.selStrobe)
		begin
			wrSelQ_r <= wrPort.selBus[QSEL_W-1:0]; // R6 R22
			wrSelOwn_r <= wrSelHit; // R19
		end
	end

	// Writes follow the selection one edge late, so data lands from the second edge
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wrActQ_r <= QSEL_RESET;
			wrActOwn_r <= 1'b0;
		end
		else
		begin
			wrActQ_r <= wrSelQ_r; // R15
			wrActOwn_r <= wrSelOwn_r; // R15
		end
	end

	// ------------------------------------------------------------
	// Read-port selection and pipeline
	// ------------------------------------------------------------
	logic [QSEL_W-1:0] rdSelQ_r;
	logic rdSelNull_r;
	logic rdSelOwn_r;
	logic [QSEL_W-1:0] popQ_r;
	logic popNull_r;
	logic popOwn_r;
	logic stgValid_r;
	logic [WORD_W-1:0] stgData_r;
	logic advance;
	logic popOk;
	logic [WORD_W-1:0] popWord;
	logic rdSelHit;

	assign rdSelHit = rdPort.selBus[RADDR_W-1:RADDR_ID_LSB] == devId; // R23

	// Bit two marks the null queue whatever the two low bits hold
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rdSelQ_r <= QSEL_RESET;
			rdSelNull_r <= 1'b1;
			rdSelOwn_r <= 1'b0;
		end
		else if (rdPort.selStrobe)
		begin
			rdSelQ_r <= rdPort.selBus[QSEL_W-1:0]; // R23
			rdSelNull_r <= rdPort.selBus[RADDR_NULL_BIT]; // R1 R5
			rdSelOwn_r <= rdSelHit; // R23
		end
	end

	// The fetch side switches one edge after selection, leaving the staged word in place
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			popQ_r <= QSEL_RESET;
			popNull_r <= 1'b1;
			popOwn_r <= 1'b0;
		end
		else
		begin
			popQ_r <= rdSelQ_r;
			popNull_r <= rdSelNull_r; // R1
			popOwn_r <= rdSelOwn_r;
		end
	end

	// Output moves on a read or whenever it holds nothing valid (fall through)
	assign advance = outputWordValid_n | rdPort.enable; // R3 R4
	// The null queue never yields a word, exactly like an empty queue
	assign popOk = popOwn_r & ~popNull_r & ~qEmpty[popQ_r] & ctrl_r[CTRL_RD_ENABLE_BIT]
		& (~stgValid_r | advance); // R2

	// First stored byte lands in the low lane
	always_comb
	begin
		logic [PTR_W-1:0] p0;
		logic [PTR_W-1:0] p1;
		p0 = rdPtr_r[popQ_r];
		p1 = p0 + PTR_W'(1);
		popWord = {BYTE_W'(0), mem[{popQ_r, p0}]};
		if (!rdNarrow_r)
			popWord[WORD_W-1:BYTE_W] = mem[{popQ_r, p1}]; // R9
	end

	// Stage register: refilled whenever it empties or hands its word on
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			stgValid_r <= 1'b0;
			stgData_r <= '0;
		end
		else if (!stgValid_r || advance)
		begin
			stgValid_r <= popOk; // R3
			stgData_r <= popWord;
		end
	end

	// Output register: old word stays when nothing new arrives, valid goes high
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			readData <= '0;
			outputWordValid_n <= FLAG_RESET_N;
		end
		else if (advance)
		begin
			if (stgValid_r)
				readData <= stgData_r; // R4
			outputWordValid_n <= ~stgValid_r; // R2 R24
		end
	end

	// Valid flag driven only while the read address names this device
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			outputWordValidOe <= 1'b0;
		else
			outputWordValidOe <= rdSelOwn_r;
	end

	// ------------------------------------------------------------
	// Occupancy bookkeeping
	// ------------------------------------------------------------
	logic wrAllowed;
	assign wrAllowed = wrPort.enable & wrActOwn_r & ctrl_r[CTRL_WR_ENABLE_BIT]
		& ~qFull[wrActQ_r]; // R26

	generate
		for (genvar q = 0; q < QUEUES; q++)
		begin : gQueue
			assign doWrite[q] = wrAllowed && wrActQ_r == QSEL_W'(q);
			assign doPop[q] = popOk && popQ_r == QSEL_W'(q);
			// Full in write units, empty in read units, both from byte counts
			assign qFull[q] = (DEPTH_C - cnt_r[q]) < wrBytes; // R10
			assign qEmpty[q] = cnt_r[q] < rdBytes; // R11
			assign cntNxt[q] = cnt_r[q] + (doWrite[q] ? wrBytes : CNT_W'(0))
				- (doPop[q] ? rdBytes : CNT_W'(0));
			// Reads drain any queue, active for writing or not
			assign qFullNxt[q] = (DEPTH_C - cntNxt[q]) < wrBytes; // R13 R17

			always_ff @(posedge ref_clk)
			begin
				if (sys_rst)
				begin
					cnt_r[q] <= '0;
					wrPtr_r[q] <= '0;
					rdPtr_r[q] <= '0;
				end
				else
				begin
					cnt_r[q] <= cntNxt[q];
					if (doWrite[q])
						wrPtr_r[q] <= wrPtr_r[q] + PTR_W'(wrBytes);
					if (doPop[q])
						rdPtr_r[q] <= rdPtr_r[q] + PTR_W'(rdBytes);
				end
			end
		end
	endgenerate

	// Byte store; a wide write fills two consecutive bytes, low lane first
	always_ff @(posedge ref_clk)
	begin
		if (wrAllowed)
		begin
			mem[{wrActQ_r, wrPtr_r[wrActQ_r]}] <= wrPort.data[BYTE_W-1:0]; // R9
			if (!wrNarrow_r)
				mem[{wrActQ_r, wrPtr_r[wrActQ_r] + PTR_W'(1)}] <= wrPort.data[WORD_W-1:BYTE_W];
		end
	end

	// ------------------------------------------------------------
	// Active-queue full flag
	// ------------------------------------------------------------
	// Shows the latest selection, so a new queue appears one edge before it can be written
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			activeQueueFull_n <= FLAG_RESET_N;
		else
			activeQueueFull_n <= ~qFullNxt[wrSelQ_r]; // R13 R14 R16 R25
	end

	// Enable follows the ID match; mismatch floats the shared line without a command
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			activeQueueFullOe <= 1'b0;
		else if (wrPort.selStrobe)
			activeQueueFullOe <= wrSelHit; // R18 R20 R21
	end

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	logic wbHit;
	logic [31:0] rdMux;
	assign wbHit = wbReq.cyc & wbReq.stb & ~wbAck;

	// Unmapped addresses read zero and swallow writes
	always_comb
	begin
		rdMux = '0;
		if (wbReq.adr == REG_CTRL)
			rdMux[1:0] = ctrl_r;
		else if (wbReq.adr == REG_STATUS)
		begin
			rdMux[STAT_FULL_LSB +: QUEUES] = qFull;
			rdMux[STAT_EMPTY_LSB +: QUEUES] = qEmpty;
			rdMux[STAT_WNARROW_BIT] = wrNarrow_r;
			rdMux[STAT_RNARROW_BIT] = rdNarrow_r;
			rdMux[STAT_ID_LSB +: DEVID_W] = devId;
		end
		else
		begin
			for (int q = 0; q < QUEUES; q++)
				if (wbReq.adr == REG_LEVEL0 + 8'(q) * REG_LEVEL_STEP)
					rdMux[CNT_W-1:0] = cnt_r[q];
		end
	end

	// One-cycle ack, dropped the cycle after; a master still holding the request gets a new ack the cycle after that
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wbAck <= 1'b0;
			wbDatOut <= '0;
			ctrl_r <= CTRL_RESET;
		end
		else
		begin
			wbAck <= wbHit;
			if (wbHit)
				wbDatOut <= rdMux;
			if (wbHit && wbReq.we && wbReq.sel[0] && wbReq.adr == REG_CTRL)
				ctrl_r <= wbReq.dat[1:0];
		end
	end

endmodule

// file: verification/mqf_queue_core_chk.sv
// Port checker of the queue core
`timescale 1ns/10ps
module mqf_queue_core_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic [2:0] deviceIdentPins,
	input wire logic outputWidthSelect,
	input wire mqf_pkg::mqf_wr_port_s wrPort,
	input wire logic activeQueueFull_n,
	input wire logic activeQueueFullOe,
	input wire mqf_pkg::mqf_rd_port_s rdPort,
	input wire logic [17:0] readData,
	input wire logic outputWordValid_n,
	input wire logic outputWordValidOe,
	input wire mqf_pkg::mqf_wb_req_s wbReq,
	input wire logic wbAck
);
	import mqf_pkg::*;
	// ----
	// Port relations
	// ----
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Line ownership follows the ID carried by each selection
	a_full_own: assert property (wrPort.selStrobe |=> activeQueueFullOe ==
		($past(wrPort.selBus[4:2]) == deviceIdentPins)) else $error("full owner");
	a_full_keep: assert property (!wrPort.selStrobe |=> $stable(activeQueueFullOe))
		else $error("full owner moved");
	a_full_idle: assert property ($fell(sys_rst) |-> activeQueueFull_n &&
		!activeQueueFullOe) else $error("full after reset");
	// The valid-line enable trails the latched selection by one more edge
	a_valid_own: assert property (rdPort.selStrobe |=> ##1 outputWordValidOe ==
		($past(rdPort.selBus[5:3], 2) == deviceIdentPins)) else $error("valid owner");
	// Null queue drains the pipeline, then reads as empty
	a_null_empty: assert property (rdPort.selStrobe && rdPort.selBus[2] ##1
		(rdPort.enable && !rdPort.selStrobe)[*5] |=> outputWordValid_n) else $error("null");
	// No enable and a valid word: nothing is loaded
	a_word_hold: assert property (!rdPort.enable && !outputWordValid_n |=>
		$stable(readData) && !outputWordValid_n) else $error("word lost");
	a_narrow_out: assert property (outputWidthSelect && !outputWordValid_n |->
		readData[17:9] == 9'h000) else $error("narrow upper");
	a_ack_once: assert property (wbAck |=> !wbAck) else $error("ack long");
	a_ack_reply: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
		else $error("no ack");
endmodule

// file: verification/mqf_ctrl_model.sv
// Controller model: read port driver and shared flag lines
`timescale 1ns/10ps
module mqf_ctrl_model (
	// Clock
	input wire logic ref_clk,
	// Device flag pins
	input wire logic activeQueueFull_n,
	input wire logic activeQueueFullOe,
	input wire logic outputWordValid_n,
	input wire logic outputWordValidOe,
	// Read port and resolved lines
	output mqf_pkg::mqf_rd_port_s rdPort,
	output logic fullLine,
	output logic validLine
);
	import mqf_pkg::*;
	// ----
	// Shared lines
	// ----
	// Pull-ups: a line nobody drives reads high
	assign fullLine = activeQueueFullOe ? activeQueueFull_n : 1'b1;
	assign validLine = outputWordValidOe ? outputWordValid_n : 1'b1;
	// Park on the null queue until data is wanted
	initial rdPort = '{1'b0, 6'h04, 1'b0};
	// One-edge select; the released bus carries junk, not the old value
	task automatic rsel(input logic [RADDR_W-1:0] a);
		rdPort.selStrobe <= 1'b1;
		rdPort.selBus <= a;
		@(posedge ref_clk);
		rdPort.selStrobe <= 1'b0;
		rdPort.selBus <= ~a;
	endtask
	task automatic ren(input logic e);
		rdPort.enable <= e;
	endtask
endmodule

// file: verification/multi_queue_full_flag_null_queue_test.sv
// Self-checking bench of the queue core
`timescale 1ns/10ps
module multi_queue_full_flag_null_queue_test;
	import mqf_pkg::*;
	localparam logic [2:0] ID = 3'h5;
	localparam int DEPTH = 16;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic iw = 1'b0;
	logic ow = 1'b0;
	mqf_wr_port_s wr = '0;
	mqf_rd_port_s rd;
	mqf_wb_req_s wb = '0;
	logic fullN, fullOe, validN, validOe, wbAck, fullLine, validLine;
	logic [17:0] rdData, lastWord;
	logic [31:0] wbDat;
	logic [31:0] rng = 32'h543340BD;
	logic [8:0] exq[$];
	int errTotal = 0;
	int samplesChecked = 0;
	int cycles = 0;
	always #4 ref_clk = ~ref_clk;
	mqf_queue_core #(.DEPTH(DEPTH)) u_mqf_queue_core (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.deviceIdentPins(ID), .inputWidthSelect(iw), .outputWidthSelect(ow), .wrPort(wr),
		.activeQueueFull_n(fullN), .activeQueueFullOe(fullOe), .rdPort(rd), .readData(rdData),
		.outputWordValid_n(validN), .outputWordValidOe(validOe), .wbReq(wb),
		.wbDatOut(wbDat), .wbAck(wbAck));
	mqf_ctrl_model u_mqf_ctrl_model (.ref_clk(ref_clk), .activeQueueFull_n(fullN),
		.activeQueueFullOe(fullOe), .outputWordValid_n(validN),
		.outputWordValidOe(validOe), .rdPort(rd), .fullLine(fullLine), .validLine(validLine));
	// ----
	// Helpers
	// ----
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Writes that fill a queue: space is counted in write-port units
	function automatic int units(input logic w9);
		return w9 ? DEPTH : DEPTH / 2;
	endfunction
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			errTotal++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic completeRun();
		if (errTotal == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			errTotal++;
			completeRun();
		end
	end
	// Straps change only inside reset, where they are latched
	task automatic rst(input logic [1:0] m);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		iw <= m[1];
		ow <= m[0];
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		exq.delete();
	endtask
	// Classic cycle: request held until ack is seen at an edge
	task automatic wbx(input logic we, input logic [7:0] a, output logic [31:0] q);
		@(posedge ref_clk);
		wb <= '{1'b1, 1'b1, we, 4'hF, a, 32'h3};
		do
			@(posedge ref_clk);
		while (wbAck !== 1'b1);
		q = wbDat;
		wb <= '0;
	endtask
	// Select a write queue; full shows the new queue one edge later
	task automatic wsel(input logic [4:0] a, input logic expFull);
		@(posedge ref_clk);
		wr.selStrobe <= 1'b1;
		wr.selBus <= a;
		@(posedge ref_clk);
		wr.selStrobe <= 1'b0;
		wr.selBus <= ~a;
		#1 chk(fullOe, a[4:2] == ID);
		@(posedge ref_clk);
		#1 chk(fullLine, !expFull);
	endtask
	// Random writes; dropped ones stay out of the byte log
	task automatic wput(input int n, input logic keep);
		repeat (n)
		begin
			@(posedge ref_clk);
			rng = xs(rng);
			wr.enable <= 1'b1;
			wr.data <= rng[17:0];
			if (keep)
				exq.push_back(rng[8:0]);
			if (keep && !iw)
				exq.push_back(rng[17:9]);
		end
		@(posedge ref_clk);
		wr.enable <= 1'b0;
	endtask
	// Read with enable held; each shown word is checked before the edge that takes it
	task automatic rget(input int n);
		logic [17:0] e;
		u_mqf_ctrl_model.ren(1'b1);
		repeat (n)
		begin
			#1;
			if (validLine === 1'b0 && exq.size() == 0)
				chk(validLine, 1'b1);
			else if (validLine === 1'b0)
			begin
				e = '0;
				e[8:0] = exq.pop_front();
				if (!ow)
					e[17:9] = exq.pop_front();
				lastWord = e;
				chk(rdData, e);
			end
			@(posedge ref_clk);
		end
		u_mqf_ctrl_model.ren(1'b0);
		#1;
		chk(18'(exq.size()), 18'h0);
		chk(validLine, 1'b1);
	endtask
	// ----
	// Scenarios, once per width pair
	// ----
	initial
	begin
		logic [31:0] q;
		logic [1:0] qs;
		for (int m = 0; m < 4; m++)
		begin
			rst(m[1:0]);
			wbx(1'b0, REG_STATUS, q);
			chk(q[17:0], {3'h0, ID, 2'h0, ow, iw, 8'hF0});
			wbx(1'b0, 8'h40, q);
			chk(q[17:0], 18'h0);
			wbx(1'b1, REG_CTRL, q);
			rng = xs(rng);
			qs = rng[1:0];
			wsel({ID, qs}, 1'b0);
			wput(units(iw) - 1, 1'b1);
			#1 chk(fullLine, 1'b1);
			wput(1, 1'b1);
			#1 chk(fullLine, 1'b0);
			wput(2, 1'b0);
			wbx(1'b0, REG_LEVEL0 + 8'(qs) * REG_LEVEL_STEP, q);
			chk(q[17:0], 18'(DEPTH));
			wsel({ID, qs + 2'h1}, 1'b0);
			wsel({ID, qs}, 1'b1);
			wsel({~ID, qs}, 1'b0);
			@(posedge ref_clk);
			u_mqf_ctrl_model.rsel({ID, 1'b0, qs});
			rget(24);
			wsel({ID, qs}, 1'b0);
			wput(iw ? 2 : 1, 1'b1);
			@(posedge ref_clk);
			u_mqf_ctrl_model.rsel({ID, 1'b0, qs});
			repeat (5) @(posedge ref_clk);
			u_mqf_ctrl_model.rsel({ID, 3'h7});
			rget(10);
			chk(rdData, lastWord);
		end
		completeRun();
	end
endmodule
bind mqf_queue_core mqf_queue_core_chk u_mqf_queue_core_chk (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .deviceIdentPins(deviceIdentPins),
	.outputWidthSelect(outputWidthSelect), .wrPort(wrPort),
	.activeQueueFull_n(activeQueueFull_n), .activeQueueFullOe(activeQueueFullOe),
	.rdPort(rdPort), .readData(readData), .outputWordValid_n(outputWordValid_n),
	.outputWordValidOe(outputWordValidOe), .wbReq(wbReq), .wbAck(wbAck));
